/* File: verilog/sacc_regs.sv */
// apb register bank and filter lookup for the shared address cam entries
`timescale 1ns/10ps
`include "sacc_params.svh"
module sacc_regs
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // validity flags of entries 1..24, kept elsewhere
  input wire logic [23:0] lower_valid,
  // filter lookup
  input wire sacc_pkg::sacc_cmp_req_type cmp_req,
  output sacc_pkg::sacc_cmp_rsp_type cmp_rsp
);
  import sacc_pkg::*;

  logic [7:0] shared_entry_valid_reg;
  logic [4:0] entry_sel;
  logic [2:0] byte_ptr;
  logic sec_enable;
  logic [47:0] cam_addr [`SACC_ENTRIES];
  logic [12:0] entry_port_mask [`SACC_ENTRIES];
  logic [31:0] all_valid;
  logic [31:0] member;
  logic [31:0] hit_vec;
  logic [7:0] reg_idx;
  logic in_range;
  logic mapped;
  logic commit;
  logic wr_commit;
  logic [31:0] next_prdata;
  logic [4:0] next_entry;
  logic [7:0] cur_byte;
  logic port_ok;
  logic [3:0] port_bit;

  // one wait state lets prdata and pready both leave flip-flops
  assign commit = psel & penable & pready;
  assign wr_commit = commit & pwrite;
  assign reg_idx = paddr[9:2];
  assign in_range = (paddr[11:10] == 2'b00) & (paddr[1:0] == 2'b00);
  assign all_valid = {shared_entry_valid_reg, lower_valid};
  assign cur_byte = cam_addr[entry_sel][{byte_ptr, 3'b000} +: 8];
  assign port_ok = (cmp_req.port >= 4'h1) & (cmp_req.port <= 4'hD);
  assign port_bit = cmp_req.port - 4'h1;

  always_comb
  begin
    mapped = in_range;
    next_prdata = 32'h00000000;
    unique case (reg_idx)
      `SACC_IDX_VALID:
        next_prdata[7:0] = shared_entry_valid_reg;
      `SACC_IDX_SEL:
        next_prdata[4:0] = entry_sel;
      `SACC_IDX_ADDR:
        next_prdata[7:0] = cur_byte;
      `SACC_IDX_MASK_LO:
        next_prdata[7:0] = entry_port_mask[entry_sel][7:0];
      `SACC_IDX_MASK_HI:
        next_prdata[7:0] = {byte_ptr, entry_port_mask[entry_sel][12:8]};
      `SACC_IDX_CTRL:
        next_prdata[`SACC_CTRL_SEC_BIT] = sec_enable;
      default:
        mapped = 1'b0;
    endcase
    if (!in_range)
    begin
      next_prdata = 32'h00000000;
    end
  end

  // bus answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready)
      begin
        pslverr <= ~mapped;
        prdata <= pwrite ? 32'h00000000 : next_prdata;
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end

  // validity flags of entries 25..32
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shared_entry_valid_reg <= `SACC_RST_VALID;
    end
    else if (wr_commit & in_range & (reg_idx == `SACC_IDX_VALID))
    begin
      shared_entry_valid_reg <= pwdata[7:0];
    end
  end

  // entry select and security enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      entry_sel <= `SACC_RST_SEL;
      sec_enable <= 1'b0;
    end
    else if (wr_commit & in_range)
    begin
      if (reg_idx == `SACC_IDX_SEL)
      begin
        entry_sel <= pwdata[4:0];
      end
      if (reg_idx == `SACC_IDX_CTRL)
      begin
        sec_enable <= pwdata[`SACC_CTRL_SEC_BIT];
      end
    end
  end

  // byte pointer: restarts on a new selection, wraps after the sixth byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      byte_ptr <= 3'h0;
    end
    else if (wr_commit & in_range & (reg_idx == `SACC_IDX_SEL))
    begin
      byte_ptr <= 3'h0;
    end
    else if (commit & in_range & (reg_idx == `SACC_IDX_ADDR))
    begin
      if (byte_ptr == `SACC_LAST_BYTE)
      begin
        byte_ptr <= 3'h0;
      end
      else
      begin
        byte_ptr <= byte_ptr + 3'h1;
      end
    end
  end

  // per-entry storage, masks and match terms
  generate
    for (genvar i = 0; i < `SACC_ENTRIES; i++)
    begin : g_entry
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          cam_addr[i] <= `SACC_RST_ADDR;
          entry_port_mask[i] <= `SACC_RST_MASK;
        end
        else if (wr_commit & in_range & (entry_sel == 5'(i)))
        begin
          if (reg_idx == `SACC_IDX_ADDR)
          begin
            cam_addr[i][{byte_ptr, 3'b000} +: 8] <= pwdata[7:0];
          end
          if (reg_idx == `SACC_IDX_MASK_LO)
          begin
            entry_port_mask[i][7:0] <= pwdata[7:0];
          end
          if (reg_idx == `SACC_IDX_MASK_HI)
          begin
            // pointer bits of the write data are dropped
            entry_port_mask[i][12:8] <= pwdata[`SACC_HI_PORTS_MSB:0];
          end
        end
      end
      // any combination of ports may claim any entry
      assign member[i] = port_ok & entry_port_mask[i][port_bit];
      assign hit_vec[i] = all_valid[i] & member[i] & (cam_addr[i] == cmp_req.addr);
    end
  endgenerate

  // lowest matching entry wins so the answer is deterministic
  always_comb
  begin
    next_entry = 5'h00;
    for (int k = `SACC_ENTRIES - 1; k >= 0; k--)
    begin
      if (hit_vec[k])
      begin
        next_entry = 5'(k);
      end
    end
  end

  // lookup answer, one cycle after the request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_rsp <= '0;
    end
    else
    begin
      cmp_rsp.done <= cmp_req.valid;
      cmp_rsp.hit <= cmp_req.valid & sec_enable & (|hit_vec);
      cmp_rsp.entry <= cmp_req.valid ? next_entry : 5'h00;
    end
  end

  // helper state for checks
  logic [31:0] chk_valid;
  logic [31:0] chk_member;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chk_valid <= 32'h00000000;
      chk_member <= 32'h00000000;
    end
    else
    begin
      chk_valid <= all_valid;
      chk_member <= member;
    end
  end

  a_valid_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_commit & in_range & (reg_idx == `SACC_IDX_VALID)
    |=> shared_entry_valid_reg == $past(pwdata[7:0]))
    else $error("valid flags not written");

  a_hit_valid: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_rsp.hit |-> chk_valid[cmp_rsp.entry])
    else $error("hit on an invalid entry");

  a_hit_member: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_rsp.hit |-> chk_member[cmp_rsp.entry] && $past(sec_enable))
    else $error("hit without port membership");

  a_ptr_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    commit & in_range & (reg_idx == `SACC_IDX_ADDR) & (byte_ptr == `SACC_LAST_BYTE)
    |=> byte_ptr == 3'h0)
    else $error("pointer did not wrap after six bytes");

  a_ptr_step: assert property (@(posedge pclk) disable iff (!presetn)
    commit & in_range & (reg_idx == `SACC_IDX_ADDR) & (byte_ptr < `SACC_LAST_BYTE)
    |=> byte_ptr == $past(byte_ptr) + 3'h1)
    else $error("pointer did not step");

  a_addr_byte: assert property (@(posedge pclk) disable iff (!presetn)
    wr_commit & in_range & (reg_idx == `SACC_IDX_ADDR)
    |=> cam_addr[$past(entry_sel)][{$past(byte_ptr), 3'b000} +: 8] == $past(pwdata[7:0]))
    else $error("address byte landed in wrong lane");

  a_mask_low: assert property (@(posedge pclk) disable iff (!presetn)
    wr_commit & in_range & (reg_idx == `SACC_IDX_MASK_LO)
    |=> entry_port_mask[$past(entry_sel)][7:0] == $past(pwdata[7:0]))
    else $error("mask low byte not written");

  a_mask_high: assert property (@(posedge pclk) disable iff (!presetn)
    wr_commit & in_range & (reg_idx == `SACC_IDX_MASK_HI)
    |=> entry_port_mask[$past(entry_sel)][12:8] == $past(pwdata[4:0]))
    else $error("mask high bits not written");

  a_ptr_readonly: assert property (@(posedge pclk) disable iff (!presetn)
    wr_commit & in_range & (reg_idx == `SACC_IDX_MASK_HI)
    |=> $stable(byte_ptr))
    else $error("pointer changed by a mask write");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    psel & penable & ~pready |=> pready ##1 !pready)
    else $error("pready not a single cycle");

  c_addr_wrap: cover property (@(posedge pclk) disable iff (!presetn)
    commit & (reg_idx == `SACC_IDX_ADDR) & (byte_ptr == `SACC_LAST_BYTE));
  c_hit: cover property (@(posedge pclk) disable iff (!presetn) cmp_rsp.hit);
  c_miss_valid: cover property (@(posedge pclk) disable iff (!presetn)
    cmp_rsp.done & !cmp_rsp.hit & sec_enable);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr & pready);
endmodule

/* File: verilog/sacc_params.svh */
// constants for the shared address cam configuration block
`ifndef SACC_PARAMS_SVH
`define SACC_PARAMS_SVH
// register indices; byte address is four times the index
`define SACC_IDX_VALID 8'h19
`define SACC_IDX_SEL 8'h1A
`define SACC_IDX_ADDR 8'h1B
`define SACC_IDX_MASK_LO 8'h1C
`define SACC_IDX_MASK_HI 8'h1D
`define SACC_IDX_CTRL 8'h1E
// field positions
`define SACC_HI_PORTS_MSB 4
`define SACC_HI_PTR_LSB 5
`define SACC_CTRL_SEC_BIT 0
// sizes and counts
`define SACC_ENTRIES 32
`define SACC_PORTS 13
`define SACC_BYTES_PER_ADDR 3'h6
`define SACC_LAST_BYTE 3'h5
// reset values
`define SACC_RST_VALID 8'h00
`define SACC_RST_SEL 5'h00
`define SACC_RST_MASK 13'h0000
`define SACC_RST_ADDR 48'h000000000000
`endif

/* File: verilog/sacc_pkg.sv */
// types shared by the shared address cam configuration block
package sacc_pkg;
  typedef struct packed
  {
    logic valid;
    logic [3:0] port;
    logic [47:0] addr;
  } sacc_cmp_req_type;
  typedef struct packed
  {
    logic done;
    logic hit;
    logic [4:0] entry;
  } sacc_cmp_rsp_type;
endpackage

/* File: testbench/shared_address_cam_config_test.sv */
// self-checking bench for the shared address cam configuration block
`timescale 1ns/10ps
`include "sacc_params.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module shared_address_cam_config_test;
  import sacc_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [23:0] lower_valid;
  sacc_cmp_req_type cmp_req;
  sacc_cmp_rsp_type cmp_rsp;
  int n_fail;
  int checks;
  logic [31:0] rd;
  logic err;
  logic [47:0] mac;
  sacc_regs uut
  (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .lower_valid(lower_valid),
    .cmp_req(cmp_req),
    .cmp_rsp(cmp_rsp)
  );
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // one apb transfer; waits for pready without assuming its latency, the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic look(input logic [3:0] port, input logic [47:0] a, input logic hit,
    input logic [4:0] ent);
    @(posedge pclk);
    cmp_req <= {1'b1, port, a};
    @(posedge pclk);
    cmp_req.valid <= 1'b0;
    @(posedge pclk);
    `CHK(cmp_rsp.done, 1'b1)
    `CHK(cmp_rsp.hit, hit)
    if (hit)
      `CHK(cmp_rsp.entry, ent)
  endtask
  task automatic t_reset;
    apb(1'b0, `SACC_IDX_VALID, 32'h0);
    `CHK(rd[7:0], 8'h00)
    apb(1'b0, `SACC_IDX_MASK_HI, 32'h0);
    `CHK(rd[7:0], 8'h00)
    apb(1'b0, 8'h3F, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("test reset and unmapped done");
  endtask
  task automatic t_addr;
    apb(1'b1, `SACC_IDX_SEL, 32'h1F);
    for (int i = 0; i < 2; i++)
      apb(1'b1, `SACC_IDX_ADDR, {24'h0, mac[8*i+:8]});
    apb(1'b1, `SACC_IDX_MASK_HI, 32'hFF);
    apb(1'b0, `SACC_IDX_MASK_HI, 32'h0);
    `CHK(rd[7:0], 8'h5F)
    for (int i = 2; i < 6; i++)
      apb(1'b1, `SACC_IDX_ADDR, {24'h0, mac[8*i+:8]});
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, `SACC_IDX_ADDR, 32'h0);
      `CHK(rd[7:0], mac[8*i+:8])
    end
    $display("test address port done");
  endtask
  task automatic t_look;
    apb(1'b1, `SACC_IDX_MASK_LO, 32'h80);
    apb(1'b0, `SACC_IDX_MASK_LO, 32'h0);
    `CHK(rd[7:0], 8'h80)
    apb(1'b1, `SACC_IDX_VALID, 32'h01);
    apb(1'b0, `SACC_IDX_VALID, 32'h0);
    apb(1'b1, `SACC_IDX_VALID, rd | 32'h80);
    apb(1'b0, `SACC_IDX_VALID, 32'h0);
    `CHK(rd[7:0], 8'h81)
    // security still off: a fully set up entry must not match yet
    look(4'hD, mac, 1'b0, 5'h0);
    apb(1'b1, `SACC_IDX_CTRL, 32'h1);
    look(4'hD, mac, 1'b1, 5'h1F);
    look(4'h9, mac, 1'b1, 5'h1F);
    look(4'h8, mac, 1'b1, 5'h1F);
    look(4'h7, mac, 1'b0, 5'h0);
    look(4'hD, ~mac, 1'b0, 5'h0);
    // a write returns zero read data, so the flags are read again before the change
    apb(1'b0, `SACC_IDX_VALID, 32'h0);
    apb(1'b1, `SACC_IDX_VALID, rd & 32'h7F);
    apb(1'b0, `SACC_IDX_VALID, 32'h0);
    `CHK(rd[7:0], 8'h01)
    look(4'hD, mac, 1'b0, 5'h0);
    $display("test lookup done");
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_fail++;
    end_sim();
  end
  initial
  begin
    n_fail = 0;
    checks = 0;
    mac = 48'hA5C31E770F92;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lower_valid = 24'hFFFFFF;
    cmp_req = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_addr();
    t_look();
    end_sim();
  end
endmodule
